// ### design/oic_pkg.sv
// Package for the option and interrupt control register bank
// Summary of operation
// - Option register decoded at 81h and 181h
// - Bit 7 high disables all pull-ups
// - Bit 6 picks external interrupt edge
// - Bit 5 picks timer0 clock source
// - Bit 4 picks external clock count edge
// - Bit 3 routes prescaler to watchdog
// - Interrupt control decoded at four mirrors
// - Flags set regardless of enables
// - Global enable gates every interrupt request
// - Bit 5 masks timer0 overflow source
// - Bit 4 masks external pin source
// - Port change flag on upper pin change
`default_nettype none
package oic_pkg;
   // -----------------------------------------------------------------
   // Register word indexes; the APB byte address is four times these
   // -----------------------------------------------------------------
   localparam logic [11:0] OIC_IDX_INTCTL_B0  = 12'h00b;
   localparam logic [11:0] OIC_IDX_INTCTL_B1  = 12'h08b;
   localparam logic [11:0] OIC_IDX_INTCTL_B2  = 12'h10b;
   localparam logic [11:0] OIC_IDX_INTCTL_B3  = 12'h18b;
   localparam logic [11:0] OIC_IDX_OPTION_B1  = 12'h081;
   localparam logic [11:0] OIC_IDX_OPTION_B3  = 12'h181;
   // -----------------------------------------------------------------
   // Field positions and reset values
   // -----------------------------------------------------------------
   localparam int OIC_OPT_PULLUP_DIS   = 7;
   localparam int OIC_OPT_EDGE_SEL     = 6;
   localparam int OIC_OPT_CLK_SRC      = 5;
   localparam int OIC_OPT_SRC_EDGE     = 4;
   localparam int OIC_OPT_PSC_ASSIGN   = 3;
   localparam int OIC_INT_GLOBAL_EN    = 7;
   localparam int OIC_INT_PERIPH_EN    = 6;
   localparam int OIC_INT_T0_EN        = 5;
   localparam int OIC_INT_EXT_EN       = 4;
   localparam int OIC_INT_PC_EN        = 3;
   localparam int OIC_INT_T0_FLAG      = 2;
   localparam int OIC_INT_EXT_FLAG     = 1;
   localparam int OIC_INT_PC_FLAG      = 0;
   localparam logic [7:0] OIC_OPTION_RST = 8'hff;
   localparam logic [7:0] OIC_INTCTL_RST = 8'h00;

   // Decoded option controls delivered to timer0 and watchdog
   typedef struct packed {
      logic       pullup_disable;
      logic       ext_edge_rising;
      logic       clock_external;
      logic       count_falling;
      logic       psc_to_watchdog;
      logic [2:0] rate;
   } oic_option_t;
endpackage
`default_nettype wire

// ### design/oic_option_and_interrupt_control.sv
// Option and interrupt control register bank with APB slave
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module oic_option_and_interrupt_control (
   // Clock and reset
   input  wire logic        i_core_clk,
   input  wire logic        i_reset_n,
   // APB slave
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [13:0] i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic [31:0]      o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   // Event sources
   input  wire logic        i_timer0_overflow,
   input  wire logic        i_ext_irq_pin,
   input  wire logic [3:0]  i_port_b_upper_pins,
   input  wire logic [7:0]  i_port_b_a_latch,
   input  wire logic        i_periph_irq_pending,
   input  wire logic        i_timer0_ext_clock_pin,
   // Controls to the timer0, watchdog and port
   output oic_pkg::oic_option_t o_option,
   output logic [7:0]       o_port_b_pullup_en,
   output logic             o_timer0_tick_ext,
   output logic [7:0]       o_timer0_div,
   output logic [7:0]       o_watchdog_div,
   output logic             o_irq_request
);
   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   logic [11:0] word_idx;
   logic        sel_opt;
   logic        sel_int;
   logic        access;
   assign word_idx = i_paddr[13:2];
   assign access   = i_psel & i_penable;

   always_comb begin
      sel_opt = 1'b0;
      sel_int = 1'b0;
      if (word_idx == oic_pkg::OIC_IDX_OPTION_B1 ||
          word_idx == oic_pkg::OIC_IDX_OPTION_B3) begin
         sel_opt = 1'b1;
      end else if (word_idx == oic_pkg::OIC_IDX_INTCTL_B0 ||
                   word_idx == oic_pkg::OIC_IDX_INTCTL_B1 ||
                   word_idx == oic_pkg::OIC_IDX_INTCTL_B2 ||
                   word_idx == oic_pkg::OIC_IDX_INTCTL_B3) begin
         sel_int = 1'b1;
      end
   end

   // Zero wait states; unmapped words answer with an error
   assign o_pready  = 1'b1;
   assign o_pslverr = access & ~sel_opt & ~sel_int;

   // ----------------------------------------------------------------
   // Edge detection of event inputs
   // ----------------------------------------------------------------
   logic       ext_pin_reg,  ext_pin_next;
   logic       t0ck_reg,     t0ck_next;
   logic [3:0] pb_reg,       pb_next;
   logic       armed_reg,    armed_next;
   logic       ext_edge;
   logic       pb_change;
   logic [7:0] option_reg,   option_next;
   logic [7:0] intctl_reg,   intctl_next;

   always_comb begin
      ext_pin_next = i_ext_irq_pin;
      t0ck_next    = i_timer0_ext_clock_pin;
      pb_next      = i_port_b_upper_pins;
      armed_next   = 1'b1;
   end

   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ext_pin_reg <= 1'b0;
         t0ck_reg    <= 1'b0;
         pb_reg      <= 4'h0;
         armed_reg   <= 1'b0;
      end else begin
         ext_pin_reg <= ext_pin_next;
         t0ck_reg    <= t0ck_next;
         pb_reg      <= pb_next;
         armed_reg   <= armed_next;
      end
   end

   // The references hold no real sample in the first cycle after reset,
   // so no edge counts until armed; a true edge in that cycle is lost
   // Polarity chosen by the edge select bit
   assign ext_edge = armed_reg &
      (option_reg[oic_pkg::OIC_OPT_EDGE_SEL] ?
       (i_ext_irq_pin & ~ext_pin_reg) :
       (~i_ext_irq_pin & ext_pin_reg));
   // Reference taken every cycle, so only fresh changes count
   assign pb_change = armed_reg &
                      (|(i_port_b_upper_pins ^ pb_reg));

   // ----------------------------------------------------------------
   // Register file next state
   // ----------------------------------------------------------------
   always_comb begin
      option_next = option_reg;
      intctl_next = intctl_reg;
      if (access && i_pwrite && sel_opt) begin
         option_next = i_pwdata[7:0];
      end
      if (access && i_pwrite && sel_int) begin
         intctl_next = i_pwdata[7:0];
      end
      // Events win over a clearing write in the same cycle
      if (i_timer0_overflow) begin
         intctl_next[oic_pkg::OIC_INT_T0_FLAG] = 1'b1;
      end
      if (ext_edge) begin
         intctl_next[oic_pkg::OIC_INT_EXT_FLAG] = 1'b1;
      end
      if (pb_change) begin
         intctl_next[oic_pkg::OIC_INT_PC_FLAG] = 1'b1;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         option_reg <= oic_pkg::OIC_OPTION_RST;
         intctl_reg <= oic_pkg::OIC_INTCTL_RST;
      end else begin
         option_reg <= option_next;
         intctl_reg <= intctl_next;
      end
   end

   // Read data mux, narrow registers in the low byte
   always_comb begin
      o_prdata = 32'h0000_0000;
      if (sel_opt) begin
         o_prdata = {24'h000000, option_reg};
      end else if (sel_int) begin
         o_prdata = {24'h000000, intctl_reg};
      end
   end

   // ----------------------------------------------------------------
   // Decoded controls
   // ----------------------------------------------------------------
   logic       src_t0;
   logic       src_ext;
   logic       src_pc;
   logic       src_per;
   logic [7:0] rate_pow;
   assign o_option = option_reg;
   assign rate_pow = 8'h01 << option_reg[2:0];

   // Pull-ups follow latches unless globally disabled
   assign o_port_b_pullup_en = option_reg[oic_pkg::OIC_OPT_PULLUP_DIS] ?
                               8'h00 : i_port_b_a_latch;

   // External tick only when external source is selected
   assign o_timer0_tick_ext = armed_reg &
      option_reg[oic_pkg::OIC_OPT_CLK_SRC] &
      (option_reg[oic_pkg::OIC_OPT_SRC_EDGE] ?
       (~i_timer0_ext_clock_pin & t0ck_reg) :
       (i_timer0_ext_clock_pin & ~t0ck_reg));

   // Divide ratio minus one; a 1:1 path for timer0 needs the watchdog route
   always_comb begin
      o_timer0_div   = 8'h00;
      o_watchdog_div = 8'h00;
      if (option_reg[oic_pkg::OIC_OPT_PSC_ASSIGN]) begin
         o_watchdog_div = rate_pow - 8'h01;
      end else begin
         o_timer0_div = {rate_pow[6:0], 1'b0} - 8'h01;
      end
   end

   // Interrupt request gating
   assign src_t0  = intctl_reg[oic_pkg::OIC_INT_T0_EN] &
                    intctl_reg[oic_pkg::OIC_INT_T0_FLAG];
   assign src_ext = intctl_reg[oic_pkg::OIC_INT_EXT_EN] &
                    intctl_reg[oic_pkg::OIC_INT_EXT_FLAG];
   assign src_pc  = intctl_reg[oic_pkg::OIC_INT_PC_EN] &
                    intctl_reg[oic_pkg::OIC_INT_PC_FLAG];
   assign src_per = intctl_reg[oic_pkg::OIC_INT_PERIPH_EN] &
                    i_periph_irq_pending;
   assign o_irq_request = intctl_reg[oic_pkg::OIC_INT_GLOBAL_EN] &
      (src_t0 | src_ext | src_pc | src_per);

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   a_opt_mirror: assert property (@(posedge i_core_clk)
      disable iff (!i_reset_n)
      access && i_pwrite && sel_opt |=> option_reg == $past(i_pwdata[7:0]))
      else $error("option write not stored");
   a_pullup_off: assert property (@(posedge i_core_clk)
      disable iff (!i_reset_n)
      option_reg[7] |-> o_port_b_pullup_en == 8'h00)
      else $error("pull-ups not disabled");
   a_ext_edge_flag: assert property (@(posedge i_core_clk)
      disable iff (!i_reset_n)
      armed_reg && option_reg[6] && $rose(i_ext_irq_pin) |=> intctl_reg[1])
      else $error("rising edge missed");
   a_ext_fall_flag: assert property (@(posedge i_core_clk)
      disable iff (!i_reset_n)
      armed_reg && !option_reg[6] && $fell(i_ext_irq_pin) |=> intctl_reg[1])
      else $error("falling edge missed");
   a_pullup_follow: assert property (@(posedge i_core_clk)
      disable iff (!i_reset_n)
      !option_reg[7] |-> o_port_b_pullup_en == i_port_b_a_latch)
      else $error("pull-ups not following latches");
   a_tick_internal: assert property (@(posedge i_core_clk)
      disable iff (!i_reset_n)
      !option_reg[5] |-> !o_timer0_tick_ext)
      else $error("external tick with internal source");
   a_tick_falling: assert property (@(posedge i_core_clk)
      disable iff (!i_reset_n)
      armed_reg && option_reg[5] && option_reg[4] &&
      $fell(i_timer0_ext_clock_pin) |-> o_timer0_tick_ext)
      else $error("falling tick missed");
   a_tick_rising: assert property (@(posedge i_core_clk)
      disable iff (!i_reset_n)
      armed_reg && option_reg[5] && !option_reg[4] &&
      $rose(i_timer0_ext_clock_pin) |-> o_timer0_tick_ext)
      else $error("rising tick missed");
   a_wdog_route: assert property (@(posedge i_core_clk)
      disable iff (!i_reset_n)
      !option_reg[3] |-> o_watchdog_div == 8'h00)
      else $error("watchdog divided while prescaler on timer0");
   a_psc_top: assert property (@(posedge i_core_clk)
      disable iff (!i_reset_n)
      !option_reg[3] && option_reg[2:0] == 3'h7 |-> o_timer0_div == 8'hff)
      else $error("timer0 top ratio wrong");
   a_psc_route: assert property (@(posedge i_core_clk)
      disable iff (!i_reset_n)
      option_reg[3] |-> o_timer0_div == 8'h00)
      else $error("timer0 divided while prescaler on watchdog");
   a_psc_ratio: assert property (@(posedge i_core_clk)
      disable iff (!i_reset_n)
      !option_reg[3] && option_reg[2:0] == 3'h0 |-> o_timer0_div == 8'h01)
      else $error("timer0 1:2 ratio wrong");
   a_int_mirror: assert property (@(posedge i_core_clk)
      disable iff (!i_reset_n)
      access && i_pwrite && sel_int |=>
      intctl_reg[7:3] == $past(i_pwdata[7:3]))
      else $error("interrupt control write not stored");
   a_flag_sticky: assert property (@(posedge i_core_clk)
      disable iff (!i_reset_n)
      i_timer0_overflow |=> intctl_reg[2])
      else $error("overflow flag not set");
   a_global_gate: assert property (@(posedge i_core_clk)
      disable iff (!i_reset_n)
      !intctl_reg[7] |-> !o_irq_request)
      else $error("request with global enable clear");
   a_periph_gate: assert property (@(posedge i_core_clk)
      disable iff (!i_reset_n)
      intctl_reg[7] && intctl_reg[6] && i_periph_irq_pending
      |-> o_irq_request)
      else $error("peripheral request blocked");
   a_t0_mask: assert property (@(posedge i_core_clk)
      disable iff (!i_reset_n)
      intctl_reg[7] && intctl_reg[5] && intctl_reg[2] |-> o_irq_request)
      else $error("timer0 request missing");
   a_ext_mask: assert property (@(posedge i_core_clk)
      disable iff (!i_reset_n)
      intctl_reg[7] && intctl_reg[4] && intctl_reg[1] |-> o_irq_request)
      else $error("pin request missing");
   a_pc_mask: assert property (@(posedge i_core_clk)
      disable iff (!i_reset_n)
      intctl_reg[7] && intctl_reg[3] && intctl_reg[0] |-> o_irq_request)
      else $error("port change request missing");
   a_flag_hold: assert property (@(posedge i_core_clk)
      disable iff (!i_reset_n)
      intctl_reg[1] && !(access && i_pwrite && sel_int) |=> intctl_reg[1])
      else $error("pin flag cleared by hardware");
   a_port_change: assert property (@(posedge i_core_clk)
      disable iff (!i_reset_n)
      armed_reg && !$stable(i_port_b_upper_pins) |=> intctl_reg[0])
      else $error("port change flag not set");
   a_pc_quiet: assert property (@(posedge i_core_clk)
      disable iff (!i_reset_n)
      !intctl_reg[0] && $stable(i_port_b_upper_pins) &&
      !(access && i_pwrite && sel_int) |=> !intctl_reg[0])
      else $error("port change flag set without change");
   a_t0_hold: assert property (@(posedge i_core_clk)
      disable iff (!i_reset_n)
      intctl_reg[2] && !(access && i_pwrite && sel_int) |=> intctl_reg[2])
      else $error("overflow flag cleared by hardware");
   c_irq_raised: cover property (@(posedge i_core_clk)
      disable iff (!i_reset_n) $rose(o_irq_request));
   c_flag_cleared: cover property (@(posedge i_core_clk)
      disable iff (!i_reset_n) $fell(intctl_reg[2]));
   c_ext_tick: cover property (@(posedge i_core_clk)
      disable iff (!i_reset_n) o_timer0_tick_ext);
   c_bad_addr: cover property (@(posedge i_core_clk)
      disable iff (!i_reset_n) o_pslverr);
   c_set_beats_clear: cover property (@(posedge i_core_clk)
      disable iff (!i_reset_n)
      i_timer0_overflow && access && i_pwrite && sel_int);
endmodule
`default_nettype wire

// ### tb/tb.sv
// Self-checking testbench for the option and interrupt control bank
`timescale 1ns/1ps
`default_nettype none
module tb;
   // ------------------------------------------------------------
   // Stimulus, observed signals and counters
   // ------------------------------------------------------------
   logic                 clk, rst_n, psel, penable, pwrite;
   logic                 ovf, ext_pin, t0_pin, periph, pready, pslverr;
   logic                 tick, irq, err;
   logic [13:0]          paddr;
   logic [31:0]          pwdata, prdata, rd, seed;
   logic [3:0]           upper;
   logic [7:0]           latch, pull, tdiv, wdiv, v;
   oic_pkg::oic_option_t opt;
   int                   miscompares, comparisons, cycles;
   logic [13:0]          ia [4] = '{14'h02c, 14'h22c, 14'h42c, 14'h62c};
   logic [7:0]           cv [4] = '{8'hff, 8'h7f, 8'hc0, 8'h80};

   oic_option_and_interrupt_control oic_option_and_interrupt_control_inst (
      .i_core_clk(clk), .i_reset_n(rst_n), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
      .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .i_timer0_overflow(ovf),
      .i_ext_irq_pin(ext_pin), .i_port_b_upper_pins(upper),
      .i_port_b_a_latch(latch), .i_periph_irq_pending(periph),
      .i_timer0_ext_clock_pin(t0_pin), .o_option(opt),
      .o_port_b_pullup_en(pull), .o_timer0_tick_ext(tick),
      .o_timer0_div(tdiv), .o_watchdog_div(wdiv), .o_irq_request(irq));

   // 100 ns clock; the ceiling is far above the few hundred cycles used
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         results();
      end
   end

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic irq_exp(input logic [7:0] r, input logic p);
      return r[7] & (r[5] & r[2] | r[4] & r[1] | r[3] & r[0] | r[6] & p);
   endfunction
   task automatic check(input string n, input logic [31:0] s, e);
      comparisons++;
      if (s !== e) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask
   // One APB transfer; request held until pready is seen high
   task automatic apb(input logic w, input logic [13:0] a,
                      input logic [7:0] d);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= {24'h0, d};
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdchk(input string n, input logic [13:0] a,
                        input logic [7:0] e);
      apb(1'b0, a, 8'h00);
      check(n, rd, {24'h0, e});
   endtask
   task automatic results();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      {rst_n, psel, penable, pwrite, ovf, ext_pin, t0_pin, periph} = '0;
      {paddr, pwdata, upper} = '0;
      latch = 8'h5a;
      seed = 32'ha8d4;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      // Reset values and a refused access
      @(negedge clk);
      check("pullup_reset", pull, 0);
      check("wdiv_reset", wdiv, 127);
      check("tdiv_reset", tdiv, 0);
      check("irq_reset", irq, 0);
      rdchk("option_reset", 14'h204, 8'hff);
      rdchk("intctl_reset", 14'h02c, 8'h00);
      apb(1'b1, 14'h300, 8'hff);
      check("unmapped_err", err, 1);
      apb(1'b0, 14'h300, 8'h00);
      check("unmapped_read", rd, 0);
      rdchk("intctl_untouched", 14'h02c, 8'h00);
      $display("test reset done");
      // Every prescale code on both targets, through both option mirrors
      for (int k = 0; k < 16; k++) begin
         seed = lfsr(seed);
         v = {seed[7:4], 4'(k)};
         apb(1'b1, k[0] ? 14'h204 : 14'h604, v);
         latch <= seed[15:8];
         rdchk("option_mirror", k[0] ? 14'h604 : 14'h204, v);
         @(negedge clk);
         check("option_out", 8'(opt), v);
         check("pullup", pull, v[7] ? 8'h00 : seed[15:8]);
         check("t0_div", tdiv, v[3] ? 0 : (8'h02 << v[2:0]) - 1);
         check("wd_div", wdiv, v[3] ? (8'h01 << v[2:0]) - 1 : 0);
         if (v[3]) check("t0_undivided", tdiv, 0);
      end
      $display("test option done");
      // Interrupt gating through all four mirrors, corners then random
      for (int i = 0; i < 12; i++) begin
         seed = lfsr(seed);
         v = (i < 4) ? cv[i] : seed[7:0];
         apb(1'b1, ia[i % 4], v);
         periph <= (i < 4) ? 1'b1 : seed[8];
         rdchk("intctl_mirror", ia[(i + 1) % 4], v);
         @(negedge clk);
         check("irq", irq, irq_exp(v, periph));
      end
      @(posedge clk) periph <= 1'b0;
      $display("test gating done");
      // External timer clock edges
      apb(1'b1, 14'h204, 8'h20);
      @(posedge clk) t0_pin <= 1'b1;
      @(negedge clk) check("tick_rise", tick, 1);
      @(negedge clk) check("tick_hold", tick, 0);
      apb(1'b1, 14'h204, 8'h30);
      @(posedge clk) t0_pin <= 1'b0;
      @(negedge clk) check("tick_fall", tick, 1);
      apb(1'b1, 14'h204, 8'h00);
      @(posedge clk) t0_pin <= 1'b1;
      @(negedge clk) check("tick_internal", tick, 0);
      $display("test tick done");
      // Flags set with all enables off, cleared only by software
      apb(1'b1, 14'h02c, 8'h00);
      apb(1'b1, 14'h204, 8'h40);
      @(posedge clk) ovf <= 1'b1;
      @(posedge clk) ovf <= 1'b0;
      rdchk("ovf_flag", 14'h02c, 8'h04);
      @(negedge clk) check("irq_masked", irq, 0);
      // Overflow at the very edge of a clearing write: the set must win
      fork
         apb(1'b1, 14'h02c, 8'h00);
         begin
            repeat (2) @(posedge clk);
            ovf <= 1'b1;
            @(posedge clk) ovf <= 1'b0;
         end
      join
      rdchk("ovf_wins", 14'h02c, 8'h04);
      apb(1'b1, 14'h02c, 8'h00);
      @(posedge clk) ext_pin <= 1'b1;
      rdchk("ext_rise", 14'h02c, 8'h02);
      apb(1'b1, 14'h02c, 8'h00);
      @(posedge clk) ext_pin <= 1'b0;
      rdchk("ext_fall_ignored", 14'h02c, 8'h00);
      apb(1'b1, 14'h204, 8'h00);
      @(posedge clk) ext_pin <= 1'b1;
      rdchk("ext_rise_ignored", 14'h02c, 8'h00);
      @(posedge clk) ext_pin <= 1'b0;
      rdchk("ext_fall", 14'h02c, 8'h02);
      apb(1'b1, 14'h02c, 8'h00);
      rdchk("no_change", 14'h02c, 8'h00);
      @(posedge clk) upper <= 4'h9;
      rdchk("port_change", 14'h02c, 8'h01);
      repeat (3) @(posedge clk);
      rdchk("flag_kept", 14'h02c, 8'h01);
      apb(1'b1, 14'h02c, 8'h89);
      @(negedge clk) check("irq_port", irq, 1);
      apb(1'b1, 14'h02c, 8'h88);
      @(negedge clk) check("irq_cleared", irq, 0);
      $display("test events done");
      results();
   end
endmodule
`default_nettype wire
